// [common/cidc_pkg.sv]
package cidc_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [9:0] PRESCALE_OFS = 10'h1E0;
  localparam logic [9:0] INCTL_OFS = 10'h1E1;
  localparam logic [9:0] SYSCTL_OFS = 10'h230;
  localparam logic [9:0] UPDATE_OFS = 10'h232;
  localparam logic [9:0] CHSYNC_OFS = 10'h240;
  localparam logic [9:0] STATUS_OFS = 10'h241;
  // ==========================================================
  // Field positions
  localparam int PDIV_LSB = 0;
  localparam int PDIV_W = 3;
  localparam int IN_PD_BIT = 4;
  localparam int IF_PD_BIT = 3;
  localparam int SRC_PD_BIT = 2;
  localparam int SRC_SEL_BIT = 1;
  localparam int BYP_BIT = 0;
  localparam int SYNC_PD_BIT = 2;
  localparam int DREF_PD_BIT = 1;
  localparam int SOFT_SYNC_BIT = 0;
  localparam int UPD_BIT = 0;
  localparam int NCH = 3;
  // ==========================================================
  // Reset values
  localparam logic [7:0] PRESCALE_RST = 8'h02;
  localparam logic [7:0] INCTL_RST = 8'h00;
  localparam logic [7:0] SYSCTL_RST = 8'h00;
  localparam logic [7:0] CHSYNC_RST = 8'h00;
  // ==========================================================
  // Prescale codes
  localparam logic [2:0] PDIV_MAX = 3'h4;
  localparam logic [2:0] PDIV_RATIO_OFS = 3'h2;
  // Direct routing selections on {source,bypass}
  localparam logic [1:0] ROUTE_OSC = 2'h2;
  localparam logic [1:0] ROUTE_EXT = 2'h0;
  typedef enum logic [1:0] {CIDC_RT_DIV, CIDC_RT_OSC, CIDC_RT_EXT}
    cidc_route_t;
endpackage

// [common/cidc_ch_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface cidc_ch_if;
  logic sync_hold;
  logic sync_pulse;
  logic ignore;
  logic held;
  logic synced;
  modport ctrl (output sync_hold, output sync_pulse, output ignore,
    input held, input synced);
  modport chan (input sync_hold, input sync_pulse, input ignore,
    output held, output synced);
endinterface
`default_nettype wire

// [core/cidc_chan_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module cidc_chan_sync (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  // Channel sync
  cidc_ch_if.chan ch
);
  typedef struct packed {
    logic held;
    logic synced;
  } cidc_cs_t;
  cidc_cs_t r;
  cidc_cs_t next_r;

  always_comb begin
    next_r = r;
    next_r.synced = 1'b0;
    if (!ch.ignore) begin
      next_r.held = ch.sync_hold;
      next_r.synced = ch.sync_pulse;
    end else begin
      next_r.held = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      r <= '0;
    end else if (ce_i) begin
      r <= next_r;
    end
  end

  assign ch.held = r.held;
  assign ch.synced = r.synced;
endmodule
`default_nettype wire

// [core/cidc_top.sv]
// Operation
// - Codes 0-4 divide by 2-6, reset 4
// - Codes 5-7 hold divider output static
// - Input control bit 4 powers input section
// - Input control bit 3 powers oscillator interface
// - Input control bit 2 powers oscillator, input
// - Bit 1 selects oscillator, else external
// - Bit 0 bypasses the prescale divider
// - System bit 2 powers down sync
// - System bit 1 powers distribution reference
// - Soft sync holds channels, falling edge syncs
// - Sync-ignore channel disregards chip sync
// - Direct route picks oscillator or external, unless bypass is set
// - Update strobe copies buffered into active
// - Update bit clears itself after transfer
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module cidc_top (
  // Clock, reset, enable
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,

  // Register port
  input wire logic [9:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,

  // Clock input section controls
  output logic [2:0] div_ratio_o,
  output logic div_static_o,
  output logic src_osc_o,
  output logic div_bypass_o,
  output logic in_pd_o,
  output logic if_pd_o,
  output logic src_pd_o,
  output logic sync_pd_o,
  output logic dref_pd_o,

  // Per channel routing and sync
  input wire logic [2:0] direct_i,
  output logic [5:0] route_o,
  output logic [2:0] ch_held_o,
  output logic [2:0] ch_synced_o
);
  // ==========================================================
  // State
  typedef struct packed {
    // Buffered copies, written by software

    logic [7:0] buf_pre;
    logic [7:0] buf_in;
    logic [7:0] buf_sys;
    logic [7:0] buf_ch;
    // Active copies, the only ones the decode reads

    logic [7:0] act_pre;
    logic [7:0] act_in;
    logic [7:0] act_sys;
    logic [7:0] act_ch;
    // Update strobe, pin synchroniser and sync edge tracking

    logic upd;
    logic [2:0] dir_s1;
    logic [2:0] dir_s2;
    logic sync_prev;
    // Registered outputs

    logic [7:0] rdata;
    logic [2:0] div_ratio;
    logic div_static;
    logic src_osc;
    logic div_bypass;
    logic in_pd;
    logic if_pd;
    logic src_pd;
    logic sync_pd;
    logic dref_pd;
    logic [5:0] route;
    logic [2:0] held;
    logic [2:0] synced;
  } cidc_st_t;

  cidc_st_t r;
  cidc_st_t next_r;
  logic [2:0] ch_held;
  logic [2:0] ch_synced;
  logic soft_sync;
  logic sync_fall;

  // ==========================================================
  // Channel sync units
  // Sync ignore comes from the active copy, so it also waits for update
  genvar g;
  generate
    for (g = 0; g < cidc_pkg::NCH; g++) begin : gen_ch
      cidc_ch_if chi ();
      assign chi.sync_hold = soft_sync;
      assign chi.sync_pulse = sync_fall;
      assign chi.ignore = r.act_ch[g];
      assign ch_held[g] = chi.held;
      assign ch_synced[g] = chi.synced;
      cidc_chan_sync u_sync (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .ce_i(ce_i),
        .ch(chi.chan)
      );
    end
  endgenerate

  // ==========================================================
  // Sync source
  // Powered-down sync circuitry neither holds nor triggers
  assign soft_sync = r.act_sys[cidc_pkg::SOFT_SYNC_BIT] &
    ~r.act_sys[cidc_pkg::SYNC_PD_BIT];

  // Powering down while the bit is set must not look like a release
  assign sync_fall = r.sync_prev & ~soft_sync &
    ~r.act_sys[cidc_pkg::SYNC_PD_BIT];

  // ==========================================================
  // Next state
  always_comb begin
    logic [2:0] code;
    logic [1:0] sb;
    code = 3'h0;
    sb = 2'h0;
    next_r = r;

    // ========================================================
    // Pin synchroniser and sync tracking
    next_r.dir_s1 = direct_i;
    next_r.dir_s2 = r.dir_s1;
    next_r.sync_prev = soft_sync;
    next_r.held = ch_held;
    next_r.synced = ch_synced;

    // ========================================================
    // Register writes land in the buffered copies, except the update strobe
    next_r.upd = 1'b0;
    if (wr_i) begin
      case (addr_i)
        cidc_pkg::PRESCALE_OFS: begin
          next_r.buf_pre = 8'h00;
          next_r.buf_pre[cidc_pkg::PDIV_LSB +: cidc_pkg::PDIV_W] =
            wdata_i[cidc_pkg::PDIV_LSB +: cidc_pkg::PDIV_W];
        end
        cidc_pkg::INCTL_OFS: begin
          next_r.buf_in = 8'h00;
          next_r.buf_in[cidc_pkg::IN_PD_BIT] = wdata_i[cidc_pkg::IN_PD_BIT];
          next_r.buf_in[cidc_pkg::IF_PD_BIT] = wdata_i[cidc_pkg::IF_PD_BIT];
          next_r.buf_in[cidc_pkg::SRC_PD_BIT] =
            wdata_i[cidc_pkg::SRC_PD_BIT];
          next_r.buf_in[cidc_pkg::SRC_SEL_BIT] =
            wdata_i[cidc_pkg::SRC_SEL_BIT];
          next_r.buf_in[cidc_pkg::BYP_BIT] = wdata_i[cidc_pkg::BYP_BIT];
        end
        cidc_pkg::SYSCTL_OFS: begin
          next_r.buf_sys = 8'h00;
          next_r.buf_sys[cidc_pkg::SYNC_PD_BIT] =
            wdata_i[cidc_pkg::SYNC_PD_BIT];
          next_r.buf_sys[cidc_pkg::DREF_PD_BIT] =
            wdata_i[cidc_pkg::DREF_PD_BIT];
          next_r.buf_sys[cidc_pkg::SOFT_SYNC_BIT] =
            wdata_i[cidc_pkg::SOFT_SYNC_BIT];
        end
        cidc_pkg::CHSYNC_OFS: begin
          next_r.buf_ch = 8'h00;
          next_r.buf_ch[cidc_pkg::NCH-1:0] = wdata_i[cidc_pkg::NCH-1:0];
        end
        cidc_pkg::UPDATE_OFS: begin
          next_r.upd = wdata_i[cidc_pkg::UPD_BIT];
        end
        default: begin
        end
      endcase
    end

    // ========================================================
    // Update transfer
    // Copy lags the strobe by one cycle so a same-cycle write lands
    if (r.upd) begin
      next_r.act_pre = r.buf_pre;
      next_r.act_in = r.buf_in;
      next_r.act_sys = r.buf_sys;
      next_r.act_ch = r.buf_ch;
    end

    // ========================================================
    // Register reads; data stand for one cycle only
    next_r.rdata = 8'h00;
    if (rd_i) begin
      case (addr_i)
        cidc_pkg::PRESCALE_OFS: begin
          next_r.rdata = r.buf_pre;
        end
        cidc_pkg::INCTL_OFS: begin
          next_r.rdata = r.buf_in;
        end
        cidc_pkg::SYSCTL_OFS: begin
          next_r.rdata = r.buf_sys;
        end
        cidc_pkg::UPDATE_OFS: begin
          next_r.rdata = {7'h00, r.upd};
        end
        cidc_pkg::CHSYNC_OFS: begin
          next_r.rdata = r.buf_ch;
        end
        cidc_pkg::STATUS_OFS: begin
          next_r.rdata = {2'h0, r.held, r.synced};
        end
        default: begin
          next_r.rdata = 8'h00;
        end
      endcase
    end

    // ========================================================
    // Prescale decode, from active copies only
    code = r.act_pre[cidc_pkg::PDIV_LSB +: cidc_pkg::PDIV_W];
    if (code <= cidc_pkg::PDIV_MAX) begin
      next_r.div_ratio = code + cidc_pkg::PDIV_RATIO_OFS;
      next_r.div_static = 1'b0;
    end else begin
      next_r.div_ratio = 3'h0;
      next_r.div_static = 1'b1;
    end

    // ========================================================
    // Power-down and source controls
    next_r.in_pd = r.act_in[cidc_pkg::IN_PD_BIT];
    next_r.if_pd = r.act_in[cidc_pkg::IF_PD_BIT];
    next_r.src_pd = r.act_in[cidc_pkg::SRC_PD_BIT];
    next_r.src_osc = r.act_in[cidc_pkg::SRC_SEL_BIT];
    // Illegal combination left to software; bypass still forwarded
    next_r.div_bypass = r.act_in[cidc_pkg::BYP_BIT];
    next_r.sync_pd = r.act_sys[cidc_pkg::SYNC_PD_BIT];
    next_r.dref_pd = r.act_sys[cidc_pkg::DREF_PD_BIT];

    // ========================================================
    // Direct routing per channel
    sb = {r.act_in[cidc_pkg::SRC_SEL_BIT], r.act_in[cidc_pkg::BYP_BIT]};
    for (int i = 0; i < cidc_pkg::NCH; i++) begin
      next_r.route[2*i +: 2] = 2'(cidc_pkg::CIDC_RT_DIV);
      if (r.dir_s2[i]) begin
        case (sb)
          cidc_pkg::ROUTE_OSC: begin
            next_r.route[2*i +: 2] = 2'(cidc_pkg::CIDC_RT_OSC);
          end
          cidc_pkg::ROUTE_EXT: begin
            next_r.route[2*i +: 2] = 2'(cidc_pkg::CIDC_RT_EXT);
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Registers
  // Clock enable low freezes every field, synchroniser included
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      r.upd <= 1'b0;
      r.dir_s1 <= 3'h0;
      r.dir_s2 <= 3'h0;
      r.sync_prev <= 1'b0;
      r.rdata <= 8'h00;
      r.div_static <= 1'b0;
      r.src_osc <= 1'b0;
      r.div_bypass <= 1'b0;
      r.in_pd <= 1'b0;
      r.if_pd <= 1'b0;
      r.src_pd <= 1'b0;
      r.sync_pd <= 1'b0;
      r.dref_pd <= 1'b0;
      r.route <= 6'h00;
      r.held <= 3'h0;
      r.synced <= 3'h0;
      r.buf_pre <= cidc_pkg::PRESCALE_RST;
      r.act_pre <= cidc_pkg::PRESCALE_RST;
      r.buf_in <= cidc_pkg::INCTL_RST;
      r.act_in <= cidc_pkg::INCTL_RST;
      r.buf_sys <= cidc_pkg::SYSCTL_RST;
      r.act_sys <= cidc_pkg::SYSCTL_RST;
      r.buf_ch <= cidc_pkg::CHSYNC_RST;
      r.act_ch <= cidc_pkg::CHSYNC_RST;
      r.div_ratio <= cidc_pkg::PRESCALE_RST[2:0] + cidc_pkg::PDIV_RATIO_OFS;
    end else if (ce_i) begin
      r <= next_r;
    end
  end

  // ==========================================================
  // Register port output
  assign rdata_o = r.rdata;

  // ==========================================================
  // Clock input section outputs
  assign div_ratio_o = r.div_ratio;
  assign div_static_o = r.div_static;
  assign src_osc_o = r.src_osc;
  assign div_bypass_o = r.div_bypass;
  assign in_pd_o = r.in_pd;
  assign if_pd_o = r.if_pd;
  assign src_pd_o = r.src_pd;
  assign sync_pd_o = r.sync_pd;
  assign dref_pd_o = r.dref_pd;

  // ==========================================================
  // Routing and channel sync outputs
  assign route_o = r.route;
  assign ch_held_o = r.held;
  assign ch_synced_o = r.synced;
endmodule
`default_nettype wire

// [sim/cidc_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module cidc_properties (
  // Clock and register port
  input wire logic mclk_i, arst_n_i, wr_i, rd_i,
  input wire logic [9:0] addr_i,
  input wire logic [7:0] wdata_i, rdata_o,
  // Controls
  input wire logic [2:0] div_ratio_o, ch_held_o, ch_synced_o,
  input wire logic div_static_o, src_osc_o, div_bypass_o,
  input wire logic in_pd_o, sync_pd_o,
  input wire logic [5:0] route_o
);
  // ==========================================================
  // Cycles since the last update strobe, saturating
  logic [3:0] age;
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) age <= 4'hF;
    else if (wr_i && addr_i == cidc_pkg::UPDATE_OFS && wdata_i[0])
      age <= 4'h0;
    else if (age != 4'hF) age <= age + 4'h1;
  end
  // ==========================================================
  // Properties
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  a_static_ratio: assert property (div_static_o |-> div_ratio_o == 3'h0)
    else $error("ratio not zero while static");
  a_ratio_range: assert property (!div_static_o |->
    div_ratio_o inside {[3'h2:3'h6]}) else $error("ratio out of range");
  a_upd_clear: assert property ($past(rd_i && addr_i ==
    cidc_pkg::UPDATE_OFS) && $past(age) > 4'h4 |-> rdata_o == 8'h00)
    else $error("update bit did not clear");
  // Controls may move only shortly after an update strobe
  a_ctrl_hold: assert property (!$stable({div_ratio_o, div_static_o,
    src_osc_o, div_bypass_o, in_pd_o, sync_pd_o}) |->
    age inside {[4'h1:4'h5]}) else $error("control moved without update");
  a_one_pulse: assert property (ch_synced_o != 3'h0 |=>
    ch_synced_o == 3'h0) else $error("sync pulse longer than a cycle");
  a_sync_off: assert property (sync_pd_o && $past(sync_pd_o) |->
    ch_held_o == 3'h0 && ch_synced_o == 3'h0) else $error("sync while off");
  a_route_osc: assert property (route_o[1:0] == 2'h1 |->
    src_osc_o || $past(src_osc_o)) else $error("oscillator route wrong");
  a_route_ext: assert property (route_o[1:0] == 2'h2 |->
    !src_osc_o || !$past(src_osc_o)) else $error("external route wrong");
  c_static: cover property (div_static_o);
  c_synced: cover property (ch_synced_o != 3'h0);
  c_route: cover property (route_o[1:0] == 2'h1);
endmodule
bind cidc_top cidc_properties i_cidc_properties (.*);
`default_nettype wire

// [sim/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic mclk_i, arst_n_i, ce_i, wr_i, rd_i;
  logic [9:0] addr_i;
  logic [7:0] wdata_i, rdata_o, r;
  logic [2:0] div_ratio_o, ch_held_o, ch_synced_o, direct_i, sy;
  logic div_static_o, src_osc_o, div_bypass_o, in_pd_o, if_pd_o;
  logic src_pd_o, sync_pd_o, dref_pd_o;
  logic [5:0] route_o;
  int fail_count, n_checks;
  cidc_top i_cidc_top (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .div_ratio_o(div_ratio_o),
    .div_static_o(div_static_o),
    .src_osc_o(src_osc_o),
    .div_bypass_o(div_bypass_o),
    .in_pd_o(in_pd_o),
    .if_pd_o(if_pd_o),
    .src_pd_o(src_pd_o),
    .sync_pd_o(sync_pd_o),
    .dref_pd_o(dref_pd_o),
    .direct_i(direct_i),
    .route_o(route_o),
    .ch_held_o(ch_held_o),
    .ch_synced_o(ch_synced_o)
  );
  // ==========================================================
  // Clock and sticky sync pulse capture
  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) sy <= sy | ch_synced_o;
  // ==========================================================
  // Bus and check tasks
  task chk(input logic [7:0] s, e);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  task rd(input logic [9:0] a);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 r = rdata_o;
  endtask
  // Outputs settle three edges after the strobe; five leaves margin
  task upd;
    wr(cidc_pkg::UPDATE_OFS, 8'h01);
    repeat (5) @(posedge mclk_i);
    #1;
  endtask
  // ==========================================================
  // Scenarios
  task t_reset;
    chk(div_ratio_o, 8'h04);
    chk({div_static_o, src_osc_o, div_bypass_o, in_pd_o}, 8'h00);
    chk({if_pd_o, src_pd_o, sync_pd_o, dref_pd_o}, 8'h00);
    rd(cidc_pkg::PRESCALE_OFS);
    chk(r, 8'h02);
    rd(10'h100);
    chk(r, 8'h00);
    $display("reset test done");
  endtask
  task t_prescale;
    for (int i = 0; i < 8; i++) begin
      wr(cidc_pkg::PRESCALE_OFS, 8'(i));
      repeat (5) @(posedge mclk_i);
      #1 chk(div_ratio_o, (i == 0) ? 8'h04 : (i > 5) ? 8'h00 : 8'(i + 1));
      upd;
      chk(div_static_o, 8'(i > 4));
      chk(div_ratio_o, (i > 4) ? 8'h00 : 8'(i + 2));
    end
    wr(cidc_pkg::PRESCALE_OFS, 8'h02);
    upd;
    rd(cidc_pkg::UPDATE_OFS);
    chk(r, 8'h00);
    $display("prescale test done");
  endtask
  task t_inctl;
    for (int b = 0; b < 5; b++) begin
      wr(cidc_pkg::INCTL_OFS, 8'h01 << b);
      upd;
      chk({in_pd_o, if_pd_o, src_pd_o, src_osc_o, div_bypass_o},
        8'h01 << b);
    end
    direct_i <= 3'h7;
    wr(cidc_pkg::INCTL_OFS, 8'h02);
    upd;
    chk(route_o, 8'h15);
    wr(cidc_pkg::INCTL_OFS, 8'h00);
    upd;
    chk(route_o, 8'h2A);
    wr(cidc_pkg::INCTL_OFS, 8'h01);
    upd;
    chk(route_o, 8'h00);
    direct_i <= 3'h0;
    $display("input control test done");
  endtask
  task t_sys;
    wr(cidc_pkg::SYSCTL_OFS, 8'h06);
    upd;
    chk({sync_pd_o, dref_pd_o}, 8'h03);
    wr(cidc_pkg::SYSCTL_OFS, 8'h05);
    upd;
    chk(ch_held_o, 8'h00);
    wr(cidc_pkg::SYSCTL_OFS, 8'h00);
    upd;
    $display("system test done");
  endtask
  task t_sync(input logic [7:0] ign, input logic [2:0] exp);
    wr(cidc_pkg::CHSYNC_OFS, ign);
    upd;
    rd(cidc_pkg::CHSYNC_OFS);
    chk(r, ign);
    wr(cidc_pkg::SYSCTL_OFS, 8'h01);
    upd;
    chk(ch_held_o, exp);
    rd(cidc_pkg::STATUS_OFS);
    chk(r, {2'h0, exp, 3'h0});
    @(negedge mclk_i) sy = 3'h0;
    wr(cidc_pkg::SYSCTL_OFS, 8'h00);
    upd;
    chk(sy, exp);
    chk(ch_held_o, 8'h00);
    $display("sync test done");
  endtask
  // Frozen block ignores both the write and the update strobe
  task t_freeze;
    @(posedge mclk_i);
    ce_i <= 1'b0;
    wr(cidc_pkg::PRESCALE_OFS, 8'h03);
    upd;
    chk(div_ratio_o, 8'h04);
    @(posedge mclk_i);
    ce_i <= 1'b1;
    rd(cidc_pkg::PRESCALE_OFS);
    chk(r, 8'h02);
    $display("clock enable test done");
  endtask
  // ==========================================================
  // Sequence, watchdog and verdict
  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    {wr_i, rd_i, addr_i, wdata_i, direct_i} = '0;
    ce_i = 1'b1;
    sy = 3'h0;
    fail_count = 0;
    n_checks = 0;
    arst_n_i = 1'b0;
    repeat (10) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    t_reset;
    t_prescale;
    t_inctl;
    t_sys;
    t_sync(8'h00, 3'h7);
    t_sync(8'h01, 3'h6);
    t_sync(8'h05, 3'h2);
    t_freeze;
    end_of_test;
  end
  // Tests need well under a thousand cycles
  initial begin
    #50000;
    fail_count++;
    end_of_test;
  end
endmodule
`default_nettype wire
